//--- dgp_pkg.sv
// package with register map, field positions and reset values of the dual gpio port
package dgp_pkg;
  localparam int          DGP_A_WIDTH       = 6;
  localparam int          DGP_B_WIDTH       = 8;
  localparam int          DGP_ADDR_WIDTH    = 5;
  localparam logic [4:0]  DGP_OFF_A_DATA    = 5'h00;
  localparam logic [4:0]  DGP_OFF_A_DIR     = 5'h04;
  localparam logic [4:0]  DGP_OFF_A_PULLUP  = 5'h08;
  localparam logic [4:0]  DGP_OFF_B_DATA    = 5'h0C;
  localparam logic [4:0]  DGP_OFF_B_DIR     = 5'h10;
  localparam logic [4:0]  DGP_OFF_B_PULLUP  = 5'h14;
  localparam logic [4:0]  DGP_OFF_CONFIG    = 5'h18;
  localparam int          DGP_CLKOUT_BIT    = 7;
  localparam int          DGP_A_INONLY_BIT  = 2;
  localparam int          DGP_A_OSC_BIT     = 4;
  localparam int          DGP_CFG_IRQ_BIT   = 0;
  localparam int          DGP_CFG_OSC_LSB   = 1;
  localparam logic [7:0]  DGP_DIR_RESET     = 8'h00;
  localparam logic [7:0]  DGP_PULLUP_RESET  = 8'h00;
  localparam logic [7:0]  DGP_CONFIG_RESET  = 8'h00;
  localparam logic [1:0]  DGP_OSC_INTERNAL  = 2'h0;
  localparam logic [1:0]  DGP_OSC_EXTCLK    = 2'h1;
  localparam logic [1:0]  DGP_OSC_RC        = 2'h2;
  localparam logic [1:0]  DGP_OSC_CRYSTAL   = 2'h3;
endpackage

//--- dgp_sync.sv
// two-stage synchroniser for a bus of pin levels
module dgp_sync
  import dgp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

//--- dgp_pin_bank.sv
// per-pin output enable and pullup control for one port
module dgp_pin_bank
  import dgp_pkg::*;
#(
  parameter int             WIDTH      = 8,
  parameter logic [7:0]     INPUT_ONLY = 8'h00
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_latch,
  input  wire logic [WIDTH-1:0] i_dir,
  input  wire logic [WIDTH-1:0] i_pullup_en,
  output logic      [WIDTH-1:0] o_pin_out,
  output logic      [WIDTH-1:0] o_pin_oe,
  output logic      [WIDTH-1:0] o_pullup
);
  logic [WIDTH-1:0] next_oe;
  logic [WIDTH-1:0] next_pullup;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      assign next_oe[g]     = i_dir[g] & ~INPUT_ONLY[g];
      assign next_pullup[g] = i_pullup_en[g] & ~i_dir[g];
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_oe  <= '0;
      o_pullup  <= '0;
      o_pin_out <= '0;
    end else begin
      o_pin_oe  <= next_oe;
      o_pullup  <= next_pullup;
      o_pin_out <= i_latch;
    end
  end
endmodule

//--- dgp_top.sv
// dual gpio port: register file on classic wishbone, pin control and clock output select
module dgp_top
  import dgp_pkg::*;
#(
  parameter int AW = DGP_A_WIDTH,
  parameter int BW = DGP_B_WIDTH
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_quad_bus_clock,
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [DGP_ADDR_WIDTH-1:0] i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [31:0]               i_wb_dat,
  output logic      [31:0]               o_wb_dat,
  output logic                           o_wb_ack,
  input  wire logic [AW-1:0]             i_first_port_pin,
  output logic      [AW-1:0]             o_first_port_pin,
  output logic      [AW-1:0]             o_first_port_pin_oe,
  output logic      [AW-1:0]             o_first_port_pullup,
  input  wire logic [BW-1:0]             i_second_port_pin,
  output logic      [BW-1:0]             o_second_port_pin,
  output logic      [BW-1:0]             o_second_port_pin_oe,
  output logic      [BW-1:0]             o_second_port_pullup,
  output logic                           o_oscillator_output_pin,
  output logic                           o_oscillator_output_pin_oe,
  output logic                           o_quad_bus_clock_sel
);
  logic          rst_meta;
  logic          rst_n_sync;
  logic [AW-1:0] first_port_data;
  logic [AW-1:0] first_port_direction;
  logic [7:0]    first_port_pullup_enable;
  logic [BW-1:0] second_port_data;
  logic [BW-1:0] second_port_direction;
  logic [BW-1:0] second_port_pullup_enable;
  logic [7:0]    port_config;
  logic [AW-1:0] first_pin_sync;
  logic [BW-1:0] second_pin_sync;
  logic          wb_ack_q;

  // reset release through two flip-flops
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  // bus decode
  wire       bus_req     = i_wb_cyc & i_wb_stb & ~wb_ack_q;
  wire       bus_wr      = bus_req & i_wb_we & i_wb_sel[0];
  wire       hit_a_data  = (i_wb_adr == DGP_OFF_A_DATA);
  wire       hit_a_dir   = (i_wb_adr == DGP_OFF_A_DIR);
  wire       hit_a_pull  = (i_wb_adr == DGP_OFF_A_PULLUP);
  wire       hit_b_data  = (i_wb_adr == DGP_OFF_B_DATA);
  wire       hit_b_dir   = (i_wb_adr == DGP_OFF_B_DIR);
  wire       hit_b_pull  = (i_wb_adr == DGP_OFF_B_PULLUP);
  wire       hit_config  = (i_wb_adr == DGP_OFF_CONFIG);
  wire [7:0] wr_byte     = i_wb_dat[7:0];

  // oscillator option and clock output select
  wire [1:0] osc_option  = port_config[DGP_CFG_OSC_LSB +: 2];
  wire       osc_ok      = (osc_option == DGP_OSC_INTERNAL) | (osc_option == DGP_OSC_RC);
  wire       clkout_on   = osc_ok & first_port_pullup_enable[DGP_CLKOUT_BIT];
  wire       irq_on      = port_config[DGP_CFG_IRQ_BIT];
  // bit 4 gives up its port function while the clock is routed out
  wire [AW-1:0] osc_mask   = clkout_on ? ~(AW'(1) << DGP_A_OSC_BIT) : '1;
  wire [AW-1:0] a_dir_eff  = first_port_direction & osc_mask;
  wire [AW-1:0] a_pull_eff = first_port_pullup_enable[AW-1:0] & osc_mask;

  // read views: latch for outputs, synchronised pin for inputs; port a bit 2 reads 0 while the irq bit is set
  wire [AW-1:0] a_view_raw = (first_port_direction & first_port_data) |
                             (~first_port_direction & first_pin_sync);
  wire [AW-1:0] a_mask     = irq_on ? ~(AW'(1) << DGP_A_INONLY_BIT) : '1;
  wire [AW-1:0] a_view     = a_view_raw & a_mask;
  wire [BW-1:0] b_view     = (second_port_direction & second_port_data) |
                             (~second_port_direction & second_pin_sync);

  wire [7:0] rd_byte =
    hit_a_data ? 8'(a_view) :
    hit_a_dir  ? 8'(first_port_direction) :
    hit_a_pull ? first_port_pullup_enable :
    hit_b_data ? 8'(b_view) :
    hit_b_dir  ? 8'(second_port_direction) :
    hit_b_pull ? 8'(second_port_pullup_enable) :
    hit_config ? port_config :
    8'h00;

  // data latches have no reset and accept writes in every direction state
  always_ff @(posedge i_clk_sys) begin
    if (bus_wr && hit_a_data) begin
      first_port_data <= wr_byte[AW-1:0];
    end
    if (bus_wr && hit_b_data) begin
      second_port_data <= wr_byte[BW-1:0];
    end
  end

  // control registers
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      first_port_direction      <= DGP_DIR_RESET[AW-1:0];
      second_port_direction     <= DGP_DIR_RESET[BW-1:0];
      first_port_pullup_enable  <= DGP_PULLUP_RESET;
      second_port_pullup_enable <= DGP_PULLUP_RESET[BW-1:0];
      port_config               <= DGP_CONFIG_RESET;
    end else begin
      if (bus_wr && hit_a_dir) begin
        first_port_direction <= wr_byte[AW-1:0];
      end
      if (bus_wr && hit_b_dir) begin
        second_port_direction <= wr_byte[BW-1:0];
      end
      if (bus_wr && hit_a_pull) begin
        first_port_pullup_enable <= {wr_byte[7], 1'b0, wr_byte[AW-1:0]};
      end
      if (bus_wr && hit_b_pull) begin
        second_port_pullup_enable <= wr_byte[BW-1:0];
      end
      if (bus_wr && hit_config) begin
        port_config <= {5'h00, wr_byte[2:0]};
      end
    end
  end

  // single-cycle wishbone answer
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wb_ack_q <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      wb_ack_q <= bus_req;
      o_wb_dat <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end
  assign o_wb_ack = wb_ack_q;

  dgp_sync #(
    .WIDTH (AW)
  ) u_sync_a (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_sync),
    .i_async   (i_first_port_pin),
    .o_sync    (first_pin_sync)
  );

  dgp_sync #(
    .WIDTH (BW)
  ) u_sync_b (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_sync),
    .i_async   (i_second_port_pin),
    .o_sync    (second_pin_sync)
  );

  dgp_pin_bank #(
    .WIDTH      (AW),
    .INPUT_ONLY (8'h04)
  ) u_bank_a (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (rst_n_sync),
    .i_latch     (first_port_data),
    .i_dir       (a_dir_eff),
    .i_pullup_en (a_pull_eff),
    .o_pin_out   (o_first_port_pin),
    .o_pin_oe    (o_first_port_pin_oe),
    .o_pullup    (o_first_port_pullup)
  );

  dgp_pin_bank #(
    .WIDTH      (BW),
    .INPUT_ONLY (8'h00)
  ) u_bank_b (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (rst_n_sync),
    .i_latch     (second_port_data),
    .i_dir       (second_port_direction),
    .i_pullup_en (second_port_pullup_enable),
    .o_pin_out   (o_second_port_pin),
    .o_pin_oe    (o_second_port_pin_oe),
    .o_pullup    (o_second_port_pullup)
  );

  // select flop for the clock pin; the clock itself is muxed downstream of it
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_quad_bus_clock_sel <= 1'b0;
    end else begin
      o_quad_bus_clock_sel <= clkout_on;
    end
  end
  assign o_oscillator_output_pin    = o_quad_bus_clock_sel & i_quad_bus_clock;
  assign o_oscillator_output_pin_oe = o_quad_bus_clock_sel;
endmodule

//--- dgp_board.sv
// board model: resolves each pin level from drive, pullup and external source
module dgp_board #(
  parameter int W = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_pullup,
  input  wire logic [W-1:0] i_drv_en,
  input  wire logic [W-1:0] i_drv_val,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] flt = '0;
  // an undriven pin wanders so a stale level cannot pass for a read
  always @(posedge i_clk_sys) flt <= ~o_level;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      o_level[i] = i_oe[i] ? i_out[i] : i_drv_en[i] ? i_drv_val[i] : i_pullup[i] ? 1'h1 : flt[i];
    end
  end
endmodule

//--- dgp_asserts.sv
// checker of pin control and read data against bus traffic
module dgp_asserts
  import dgp_pkg::*;
#(
  parameter int AW = DGP_A_WIDTH,
  parameter int BW = DGP_B_WIDTH
) (
  input wire logic          i_clk_sys,
  input wire logic          i_rst_n,
  input wire logic          i_quad_bus_clock,
  input wire logic          i_wb_cyc,
  input wire logic          i_wb_stb,
  input wire logic          i_wb_we,
  input wire logic [4:0]    i_wb_adr,
  input wire logic [3:0]    i_wb_sel,
  input wire logic [31:0]   i_wb_dat,
  input wire logic [31:0]   o_wb_dat,
  input wire logic          o_wb_ack,
  input wire logic [AW-1:0] o_first_port_pin_oe,
  input wire logic [AW-1:0] o_first_port_pullup,
  input wire logic [BW-1:0] o_second_port_pin,
  input wire logic [BW-1:0] o_second_port_pin_oe,
  input wire logic [BW-1:0] o_second_port_pullup,
  input wire logic          o_oscillator_output_pin,
  input wire logic          o_oscillator_output_pin_oe,
  input wire logic          o_quad_bus_clock_sel
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire logic       acc = i_wb_cyc && i_wb_stb && o_wb_ack;
  wire logic       wr  = acc && i_wb_we && i_wb_sel[0];
  wire logic       rd  = acc && !i_wb_we;
  wire logic [7:0] wd  = i_wb_dat[7:0];
  chk_pull_off_out: assert property ((o_second_port_pin_oe & o_second_port_pullup) == '0
    && (o_first_port_pin_oe & o_first_port_pullup) == '0) else $error("pullup on driven pin");
  chk_bit2_no_drive: assert property (!o_first_port_pin_oe[DGP_A_INONLY_BIT])
    else $error("input only pin driven");
  chk_b_dir_oe: assert property (wr && i_wb_adr == DGP_OFF_B_DIR
    |=> o_second_port_pin_oe == $past(wd)) else $error("port b drive wrong");
  chk_a_dir_oe: assert property (wr && i_wb_adr == DGP_OFF_A_DIR
    |=> ({2'h0, o_first_port_pin_oe} & 8'h2B) == ($past(wd) & 8'h2B)) else $error("port a drive wrong");
  chk_b_pull_set: assert property (wr && i_wb_adr == DGP_OFF_B_PULLUP
    |=> o_second_port_pullup == ($past(wd) & ~o_second_port_pin_oe)) else $error("port b pullup wrong");
  chk_clk_out_gate: assert property (o_oscillator_output_pin == (o_quad_bus_clock_sel & i_quad_bus_clock)
    && o_oscillator_output_pin_oe == o_quad_bus_clock_sel) else $error("clock output wrong");
  chk_ext_no_clk: assert property (wr && i_wb_adr == DGP_OFF_CONFIG && wd[DGP_CFG_OSC_LSB]
    |=> ##1 !o_quad_bus_clock_sel) else $error("clock output with external source");
  chk_b_read_view: assert property (rd && i_wb_adr == DGP_OFF_B_DATA
    |-> ((o_wb_dat[7:0] ^ o_second_port_pin) & o_second_port_pin_oe) == '0) else $error("port b read wrong");
  cov_b_dir: cover property (wr && i_wb_adr == DGP_OFF_B_DIR);
  cov_b_read: cover property (rd && i_wb_adr == DGP_OFF_B_DATA);
  cov_clk_out: cover property (o_oscillator_output_pin);
endmodule
bind dgp_top dgp_asserts #(.AW(AW), .BW(BW)) u_chk (.*);

//--- dual_gpio_port_pullups_tb_top.sv
// testbench of the dual gpio port: bus tasks, board models and directed checks
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; $display("Error %0t %h %h", $time, a, e); end end
module dual_gpio_port_pullups_tb_top
  import dgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, qclk = 0, cyc = 0, stb = 0, we = 0, osc_sel, osc_pin, osc_oe;
  logic [4:0]  adr = '0;
  logic [31:0] dat = '0, rdat, q;
  logic        ack;
  logic [5:0]  ae = 6'h00, av = 6'h00, apin, aout, aoe, apu;
  logic [7:0]  be = 8'hFF, bv = 8'hA5, bpin, bout, boe, bpu;
  logic [4:0]  offs [6] = '{DGP_OFF_A_DIR, DGP_OFF_A_PULLUP, DGP_OFF_B_DIR, DGP_OFF_B_PULLUP, DGP_OFF_CONFIG, 5'h1C};
  int          num_errors = 0, comparisons = 0, cycles = 0;
  dgp_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_quad_bus_clock(qclk), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_first_port_pin(apin), .o_first_port_pin(aout), .o_first_port_pin_oe(aoe), .o_first_port_pullup(apu),
    .i_second_port_pin(bpin), .o_second_port_pin(bout), .o_second_port_pin_oe(boe), .o_second_port_pullup(bpu),
    .o_oscillator_output_pin(osc_pin), .o_oscillator_output_pin_oe(osc_oe), .o_quad_bus_clock_sel(osc_sel));
  dgp_board #(.W(6)) i_board_a (.i_clk_sys(clk), .i_out(aout), .i_oe(aoe), .i_pullup(apu), .i_drv_en(ae),
    .i_drv_val(av), .o_level(apin));
  dgp_board #(.W(8)) i_board_b (.i_clk_sys(clk), .i_out(bout), .i_oe(boe), .i_pullup(bpu), .i_drv_en(be),
    .i_drv_val(bv), .o_level(bpin));
  initial forever #4 clk = ~clk;
  always @(posedge clk) qclk <= ~qclk;
  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic reset_dut();
    rst_n <= 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    reset_dut();
    foreach (offs[i]) begin
      wb(offs[i], 1'h0, 8'h00);
      `CHK(q, 32'h0)
    end
    wb(DGP_OFF_B_DATA, 1'h1, 8'h3C);
    wb(DGP_OFF_B_DATA, 1'h0, 8'h00);
    `CHK(q[7:0], 8'hA5)
    wb(DGP_OFF_B_DIR, 1'h1, 8'h0F);
    wb(DGP_OFF_B_DATA, 1'h0, 8'h00);
    `CHK(q[7:0], 8'hAC)
    `CHK(boe, 8'h0F)
    be <= 8'h00;
    wb(DGP_OFF_B_PULLUP, 1'h1, 8'hFF);
    repeat (3) @(posedge clk);
    wb(DGP_OFF_B_DATA, 1'h0, 8'h00);
    `CHK(q[7:0], 8'hFC)
    `CHK(bpu, 8'hF0)
    wb(DGP_OFF_B_PULLUP, 1'h1, 8'h00);
    `CHK(bpu, 8'h00)
    wb(DGP_OFF_B_PULLUP, 1'h1, 8'hFF);
    wb(DGP_OFF_B_DIR, 1'h1, 8'h00);
    `CHK(bpu, 8'hFF)
    reset_dut();
    wb(DGP_OFF_B_DIR, 1'h1, 8'hFF);
    wb(DGP_OFF_B_DATA, 1'h0, 8'h00);
    `CHK(q[7:0], 8'h3C)
    `CHK(bout, 8'h3C)
    ae <= 6'h3F;
    av <= 6'h04;
    wb(DGP_OFF_A_DATA, 1'h1, 8'h2A);
    wb(DGP_OFF_A_DIR, 1'h1, 8'h3F);
    `CHK(aoe, 6'h3B)
    `CHK(aout, 6'h2A)
    wb(DGP_OFF_A_PULLUP, 1'h1, 8'hFF);
    wb(DGP_OFF_A_PULLUP, 1'h0, 8'h00);
    `CHK(q[7:0], 8'hBF)
    `CHK(aoe, 6'h2B)
    `CHK(apu, 6'h00)
    for (int i = 0; i < 4; i++) begin
      wb(DGP_OFF_CONFIG, 1'h1, 8'(i * 2));
      repeat (2) @(posedge clk);
      `CHK(osc_sel, (i % 2 == 0))
      `CHK({osc_oe, osc_pin}, {(i % 2 == 0), ((i % 2 == 0) && qclk)})
    end
    wb(DGP_OFF_A_PULLUP, 1'h1, 8'h3F);
    wb(DGP_OFF_A_DIR, 1'h1, 8'h00);
    `CHK(apu, 6'h3F)
    wb(DGP_OFF_CONFIG, 1'h1, 8'h01);
    wb(DGP_OFF_A_DATA, 1'h0, 8'h00);
    `CHK(q[7:0], 8'h00)
    wb(DGP_OFF_CONFIG, 1'h1, 8'h00);
    wb(DGP_OFF_A_DATA, 1'h0, 8'h00);
    `CHK(q[7:0], 8'h04)
    print_verdict();
  end
endmodule
